/* File: rtl/dsf_pkg.sv */
// Package with constants and carrier types for the deck status and first-seek logic.
`default_nettype none
package dsf_pkg;
    localparam int CLK_HZ = 40_000_000;
    localparam int IRQ_PULSE_NS = 1000;
    localparam int IRQ_PULSE_CYC = (IRQ_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int BRUSH_S = 60;
    localparam int HOME_MS = 300;
    localparam int ENGAGE_MS = 5;
    localparam int FAIL_MS = 600;
    // The brush period in clock cycles is beyond the range of a 32-bit signed integer.
    localparam longint BRUSH_CYC = longint'(BRUSH_S) * CLK_HZ;
    localparam int HOME_CYC = HOME_MS * (CLK_HZ / 1000);
    localparam int ENGAGE_CYC = (ENGAGE_MS * CLK_HZ + 999) / 1000;
    localparam int FAIL_CYC = FAIL_MS * (CLK_HZ / 1000);
    localparam int DECK_NUM_W = 4;
    localparam int HEAD_W = 8;
    localparam int TMR_W = 32;
    localparam logic [31:0] APB_ERR_DATA = 32'h0000_0000;
    localparam logic [11:0] ADDR_DECK_NUM = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam int ST_CHOSEN = 0;
    localparam int ST_USABLE = 1;
    localparam int ST_FAULT = 2;
    localparam int ST_REACHED = 3;
    localparam int ST_FAILED = 4;
    localparam int ST_FWD = 5;
    localparam int ST_HOME = 6;
    localparam int ST_PAWL = 7;

    typedef enum logic [1:0] {SPD_FAST, SPD_MEDIUM, SPD_CREEP} dsf_speed_t;

    typedef struct packed {
        logic read_gate;
        logic write_gate;
        logic erase_gate;
        logic [HEAD_W-1:0] head_sel;
        logic write_drv_a;
        logic write_drv_b;
        logic erase_drv;
        logic low_voltage;
    } dsf_rw_t;

    typedef struct packed {
        logic forward;
        dsf_speed_t speed;
        logic pawl_release;
    } dsf_act_t;
endpackage : dsf_pkg
`default_nettype wire

/* File: rtl/dsf_deck.sv */
// Deck status outputs and power-on first-seek sequence with an APB register port.
//
// The placing of the registers and register access over APB are this design's own decisions.
`default_nettype none
// What this block does
// - Matching pick strobe and number gives acknowledge high if usable, else low.
// - Selected deck passes one index pulse per pack revolution.
// - Any fault raises write fault and blocks write and erase current.
// - Fault on several heads, or read gate with write or erase gate.
// - Fault on erase without write driver, or both writers without eraser.
// - Fault on any read, write or erase gate without track-reached.
// - Usable needs pack in, speed up, heads loaded and on-line switch.
// - Interrupt output is driven whether or not the deck is selected.
// - Interrupt is one microsecond pulse on track-reached onset or seek failure.
// - Usable and interrupt ungated; chosen, index and write fault only from the selected deck.
// - Brush motor start at power-on starts a sixty second cleaning period.
// - At speed, enable next deck power and creep actuator forward home.
// - Brush cycle end sets forward latch for a fast forward head load.
// - Heads-loaded transition sets home-return, clearing forward for fast reverse.
// - Home timer clears home-return, setting forward, medium and creep speed.
// - Leading edge of the first track pulse sets the pawl-release flip-flop.
// - Track-reached follows pawl engagement by a fixed five millisecond delay.
// - Failure timer from heads-loaded reports failure if track-reached is late.
// - Only the deck whose four-line number matches the strobe begins selection.
// - Clear input resets the selected state whenever the clock enable is high.
module dsf_deck
    import dsf_pkg::*;
#(
    parameter longint BRUSH_CYCLES = BRUSH_CYC,
    parameter int HOME_CYCLES = HOME_CYC,
    parameter int ENGAGE_CYCLES = ENGAGE_CYC,
    parameter int FAIL_CYCLES = FAIL_CYC
)(
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic clk_en_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic pready_out,
    output logic pslverr_out,
    output logic [31:0] prdata_out,
    input wire logic pick_strobe_in,
    input wire logic [DECK_NUM_W-1:0] pick_num_in,
    input wire logic clear_in,
    input wire logic pack_in_in,
    input wire logic at_speed_in,
    input wire logic heads_loaded_in,
    input wire logic online_in,
    input wire logic brush_sw_in,
    input wire logic track_pulse_in,
    input wire logic pawl_engaged_in,
    input wire logic index_in,
    input wire dsf_rw_t rw_in,
    output logic chosen_out,
    output logic usable_out,
    output logic index_out,
    output logic write_fault_out,
    output logic irq_out,
    output logic brush_motor_out,
    output logic next_deck_pwr_out,
    output logic actuator_en_out,
    output logic write_cur_en_out,
    output logic erase_cur_en_out,
    output dsf_act_t act_out
);
    typedef enum logic [2:0] {FS_IDLE, FS_BRUSH, FS_LOAD, FS_HOME, FS_CREEP,
                              FS_SETTLE, FS_DONE, FS_FAIL} dsf_fs_t;
    localparam int NSYNC = 7;

    function automatic logic dsf_multi_hot(input logic [HEAD_W-1:0] v);
        return (v & (v - HEAD_W'(1))) != '0;
    endfunction : dsf_multi_hot

    logic [NSYNC-1:0] raw, s1_q, s2_q, s3_q;
    logic pack_s, speed_s, loaded_s, online_s, brush_s, track_s, pawl_s;
    logic loaded_edge, brush_rise, track_rise, pawl_rise, index_rise;
    dsf_fs_t fs_q;
    logic [TMR_W-1:0] tmr_q, fail_q;
    logic [7:0] irq_cnt_q;
    logic fwd_q, medium_q, creep_q, home_q, pawl_q, reached_q, failed_q;
    logic chosen_q, sel_q, fault_raw, usable_raw, index_q, fault_q;
    logic [DECK_NUM_W-1:0] my_num_q;
    logic apb_acc;
    logic fail_hit, reach_hit;

    assign raw = {index_in, pawl_engaged_in, track_pulse_in, brush_sw_in,
                  heads_loaded_in, at_speed_in, pack_in_in & online_in};

    always_ff @(posedge clk_in or posedge sys_rst_in)
        if (sys_rst_in)
        begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end
        else if (clk_en_in)
        begin
            s1_q <= raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end

    // The third stage only remembers the settled level, so no edge reads a metastable bit.
    assign {pawl_s, track_s, brush_s, loaded_s, speed_s, pack_s} = s2_q[5:0];
    assign online_s = s2_q[0];
    assign loaded_edge = loaded_s ^ s3_q[2];
    assign brush_rise = brush_s & ~s3_q[3];
    assign track_rise = track_s & ~s3_q[4];
    assign pawl_rise = pawl_s & ~s3_q[5];
    assign index_rise = s2_q[6] & ~s3_q[6];

    // Failure outranks a reach in the same cycle, so the deck never reports both.
    assign fail_hit = fail_q == TMR_W'(1) && !reached_q;
    assign reach_hit = fs_q == FS_SETTLE && !failed_q && !pawl_rise && !fail_hit
                       && tmr_q == TMR_W'(1);

    // First-seek sequencer and timers.
    always_ff @(posedge clk_in or posedge sys_rst_in)
        if (sys_rst_in)
        begin
            fs_q <= FS_IDLE;
            tmr_q <= '0;
            fwd_q <= 1'b0;
            medium_q <= 1'b0;
            creep_q <= 1'b0;
            home_q <= 1'b0;
            pawl_q <= 1'b0;
            reached_q <= 1'b0;
        end
        else if (clk_en_in)
        begin
            if (tmr_q != '0)
                tmr_q <= tmr_q - 1'b1;
            case (fs_q)
                FS_IDLE:
                begin
                    tmr_q <= TMR_W'(BRUSH_CYCLES);
                    creep_q <= 1'b1;
                    fs_q <= FS_BRUSH;
                end
                FS_BRUSH:
                    if (brush_rise && speed_s)
                    begin
                        fwd_q <= 1'b1;
                        creep_q <= 1'b0;
                        fs_q <= FS_LOAD;
                    end
                    else if (speed_s)
                        fwd_q <= 1'b1;
                FS_LOAD:
                    if (loaded_edge)
                    begin
                        home_q <= 1'b1;
                        fwd_q <= 1'b0;
                        tmr_q <= TMR_W'(HOME_CYCLES);
                        fs_q <= FS_HOME;
                    end
                FS_HOME:
                    if (tmr_q == TMR_W'(1))
                    begin
                        home_q <= 1'b0;
                        fwd_q <= 1'b1;
                        medium_q <= 1'b1;
                        creep_q <= 1'b1;
                        fs_q <= FS_CREEP;
                    end
                FS_CREEP:
                    if (failed_q)
                        fs_q <= FS_FAIL;
                    else if (track_rise)
                    begin
                        pawl_q <= 1'b1;
                        fs_q <= FS_SETTLE;
                    end
                FS_SETTLE:
                    if (failed_q)
                        fs_q <= FS_FAIL;
                    else if (pawl_rise)
                        tmr_q <= TMR_W'(ENGAGE_CYCLES);
                    else if (reach_hit)
                    begin
                        reached_q <= 1'b1;
                        fs_q <= FS_DONE;
                    end
                FS_DONE: ;
                FS_FAIL: ;
                default: fs_q <= FS_IDLE;
            endcase
        end

    // Failure timer runs from the heads-loaded transfer until track-reached.
    always_ff @(posedge clk_in or posedge sys_rst_in)
        if (sys_rst_in)
        begin
            fail_q <= '0;
            failed_q <= 1'b0;
        end
        else if (clk_en_in)
        begin
            if (fs_q == FS_LOAD && loaded_edge)
                fail_q <= TMR_W'(FAIL_CYCLES);
            else if (fail_q != '0 && !reached_q)
            begin
                fail_q <= fail_q - 1'b1;
                if (fail_hit)
                    failed_q <= 1'b1;
            end
        end

    // One-microsecond interrupt pulse, independent of selection.
    always_ff @(posedge clk_in or posedge sys_rst_in)
        if (sys_rst_in)
            irq_cnt_q <= '0;
        else if (clk_en_in)
        begin
            if (reach_hit || fail_hit)
                irq_cnt_q <= 8'(IRQ_PULSE_CYC);
            else if (irq_cnt_q != '0)
                irq_cnt_q <= irq_cnt_q - 1'b1;
        end

    // Selection; the clear input wins over a pick strobe.
    assign usable_raw = pack_s & speed_s & loaded_s & online_s & s2_q[1];
    always_ff @(posedge clk_in or posedge sys_rst_in)
        if (sys_rst_in)
        begin
            sel_q <= 1'b0;
            chosen_q <= 1'b0;
        end
        else if (clk_en_in)
        begin
            if (clear_in)
            begin
                sel_q <= 1'b0;
                chosen_q <= 1'b0;
            end
            else if (pick_strobe_in && pick_num_in == my_num_q)
            begin
                sel_q <= 1'b1;
                chosen_q <= usable_raw;
            end
            else if (pick_strobe_in)
            begin
                sel_q <= 1'b0;
                chosen_q <= 1'b0;
            end
        end

    always_comb
    begin
        fault_raw = rw_in.low_voltage;
        fault_raw |= dsf_multi_hot(rw_in.head_sel);
        fault_raw |= rw_in.read_gate & (rw_in.write_gate | rw_in.erase_gate);
        fault_raw |= rw_in.erase_gate & ~(rw_in.write_drv_a | rw_in.write_drv_b);
        fault_raw |= rw_in.erase_gate & rw_in.write_drv_a & rw_in.write_drv_b
                     & ~rw_in.erase_drv;
        fault_raw |= (rw_in.read_gate | rw_in.write_gate | rw_in.erase_gate)
                     & ~reached_q;
    end

    always_ff @(posedge clk_in or posedge sys_rst_in)
        if (sys_rst_in)
        begin
            fault_q <= 1'b0;
            index_q <= 1'b0;
        end
        else if (clk_en_in)
        begin
            fault_q <= fault_raw;
            index_q <= index_rise;
        end

    assign chosen_out = chosen_q;
    assign usable_out = usable_raw;
    assign irq_out = irq_cnt_q != '0;
    assign index_out = index_q & sel_q;
    assign write_fault_out = fault_q & sel_q;
    assign write_cur_en_out = rw_in.write_gate & ~fault_raw & ~fault_q;
    assign erase_cur_en_out = rw_in.erase_gate & ~fault_raw & ~fault_q;
    assign brush_motor_out = fs_q == FS_BRUSH && tmr_q != '0;
    assign next_deck_pwr_out = speed_s;
    assign actuator_en_out = speed_s;
    assign act_out = '{forward: fwd_q,
                       speed: creep_q ? SPD_CREEP : (medium_q ? SPD_MEDIUM : SPD_FAST),
                       pawl_release: pawl_q};

    // APB slave with zero wait states; unmapped addresses give an error.
    // Read data is latched in the setup cycle, so it stands through the whole access phase.
    assign apb_acc = psel_in & penable_in;
    assign pready_out = 1'b1;
    assign pslverr_out = apb_acc && paddr_in != ADDR_DECK_NUM && paddr_in != ADDR_STATUS;
    always_ff @(posedge clk_in or posedge sys_rst_in)
        if (sys_rst_in)
            my_num_q <= '0;
        else if (clk_en_in && apb_acc && pwrite_in && paddr_in == ADDR_DECK_NUM)
            my_num_q <= pwdata_in[DECK_NUM_W-1:0];

    always_ff @(posedge clk_in or posedge sys_rst_in)
        if (sys_rst_in)
            prdata_out <= '0;
        else if (clk_en_in && psel_in && !penable_in && !pwrite_in)
        begin
            prdata_out <= APB_ERR_DATA;
            if (paddr_in == ADDR_DECK_NUM)
                prdata_out[DECK_NUM_W-1:0] <= my_num_q;
            else if (paddr_in == ADDR_STATUS)
            begin
                prdata_out[ST_CHOSEN] <= chosen_q;
                prdata_out[ST_USABLE] <= usable_raw;
                prdata_out[ST_FAULT] <= fault_q;
                prdata_out[ST_REACHED] <= reached_q;
                prdata_out[ST_FAILED] <= failed_q;
                prdata_out[ST_FWD] <= fwd_q;
                prdata_out[ST_HOME] <= home_q;
                prdata_out[ST_PAWL] <= pawl_q;
            end
        end

    // Onsets and strobes are named so that each check reads as the step it guards.
    sequence s_reach_onset;
        $rose(reached_q);
    endsequence
    sequence s_fail_onset;
        $rose(failed_q);
    endsequence
    sequence s_home_end;
        $fell(home_q);
    endsequence
    sequence s_pick_match;
        clk_en_in && !clear_in && pick_strobe_in && pick_num_in == my_num_q;
    endsequence
    sequence s_pick_other;
        clk_en_in && !clear_in && pick_strobe_in && pick_num_in != my_num_q;
    endsequence

    a_irq_width: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        $rose(irq_out) && clk_en_in |-> irq_out [*2]) else $error("irq too short");
    a_clear_wins: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        clear_in && clk_en_in |=> !chosen_out) else $error("clear ignored");
    a_fault_blocks: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        fault_raw |-> !write_cur_en_out && !erase_cur_en_out) else $error("current on");
    a_gate_reach: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        rw_in.read_gate && !reached_q && clk_en_in |=> fault_q) else $error("no fault");
    a_usable_need: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        usable_out |-> s2_q[1] && s2_q[0]) else $error("usable wrong");
    a_home_rev: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        home_q |-> !act_out.forward) else $error("home not reverse");
    a_creep_spd: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        fs_q == FS_CREEP |-> act_out.speed == SPD_CREEP && fwd_q) else $error("not creep");
    a_pawl_track: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        $rose(pawl_q) |-> $past(track_rise)) else $error("pawl early");
    a_fail_excl: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !(failed_q && $rose(reached_q))) else $error("both reported");
    a_irq_reach: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        s_reach_onset |-> irq_out) else $error("no pulse on reach");
    a_irq_fail: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        s_fail_onset |-> irq_out && !reached_q) else $error("no pulse on failure");
    a_slow_fwd: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        s_home_end |-> act_out.forward && act_out.speed == SPD_CREEP) else $error("not slow");
    a_pick_ack: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        s_pick_match |=> chosen_out == $past(usable_raw)) else $error("ack not usable");
    a_pick_other: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        s_pick_other |=> !chosen_out) else $error("other deck acknowledged");
    a_sel_gate: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !sel_q |-> !chosen_out && !index_out && !write_fault_out) else $error("not gated");
    a_enable_freeze: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !clk_en_in |=> $stable(fs_q) && $stable(tmr_q) && $stable(chosen_q))
        else $error("state moved while frozen");
endmodule : dsf_deck
`default_nettype wire

/* File: tb/dsf_ctl_model.sv */
// Control unit model that picks and clears the deck and watches for double acknowledge.
`default_nettype none
module dsf_ctl_model
    import dsf_pkg::*;
#(
    parameter int N_DECKS = 1
)(
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic sel_req_in,
    input wire logic clr_req_in,
    input wire logic [DECK_NUM_W-1:0] num_in,
    input wire logic [N_DECKS-1:0] chosen_in,
    output logic pick_strobe_out,
    output logic [DECK_NUM_W-1:0] pick_num_out,
    output logic clear_out,
    output logic dup_ack_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // The number is only valid beside the strobe; inverting it each cycle afterwards
    // exposes a deck that samples it late.
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            pick_strobe_out <= 1'b0;
            pick_num_out <= '0;
            clear_out <= 1'b0;
        end
        else
        begin
            pick_strobe_out <= sel_req_in;
            pick_num_out <= sel_req_in ? num_in : ~pick_num_out;
            clear_out <= clr_req_in;
        end
    end
    assign dup_ack_out = $countones(chosen_in) > 1;
endmodule : dsf_ctl_model
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking testbench for the deck status and first-seek logic.
`default_nettype none
module tb_top
    import dsf_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BR = 20, HM = 20, EG = 10, FL = 200;
    logic clk_in = 1'b0, sys_rst_in = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pack = 1'b0, speed = 1'b0, loaded = 1'b0, online = 1'b0, brush = 1'b0;
    logic track = 1'b0, pawl = 1'b0, index = 1'b0, sel_req = 1'b0, clr_req = 1'b0;
    logic [3:0] num = 4'h0, pick_num;
    logic pready, pslverr, err, pick_strobe, clear, chosen, usable, index_o, fault, irq;
    logic brush_m, next_pwr, act_en, wcur, ecur, dup, ce = 1'b1;
    dsf_rw_t rw = '0;
    dsf_act_t act;
    dsf_rw_t rows [8] = '{15'h4010, 15'h4030, 15'h6010, 15'h5010, 15'h3010, 15'h301C,
        15'h301A, 15'h301B};
    logic [7:0] flt = 8'hBE;
    int bad_count = 0, n_tests = 0, cyc = 0, cnt;

    always #12.5 clk_in = ~clk_in;

    dsf_deck #(.BRUSH_CYCLES(BR), .HOME_CYCLES(HM), .ENGAGE_CYCLES(EG), .FAIL_CYCLES(FL)) dut (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .clk_en_in(ce), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .pready_out(pready), .pslverr_out(pslverr), .prdata_out(prdata),
        .pick_strobe_in(pick_strobe), .pick_num_in(pick_num), .clear_in(clear),
        .pack_in_in(pack), .at_speed_in(speed), .heads_loaded_in(loaded), .online_in(online),
        .brush_sw_in(brush), .track_pulse_in(track), .pawl_engaged_in(pawl),
        .index_in(index), .rw_in(rw), .chosen_out(chosen), .usable_out(usable),
        .index_out(index_o), .write_fault_out(fault), .irq_out(irq), .brush_motor_out(brush_m),
        .next_deck_pwr_out(next_pwr), .actuator_en_out(act_en), .write_cur_en_out(wcur),
        .erase_cur_en_out(ecur), .act_out(act));

    dsf_ctl_model #(.N_DECKS(1)) ctl (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .sel_req_in(sel_req), .clr_req_in(clr_req), .num_in(num), .chosen_in(chosen),
        .pick_strobe_out(pick_strobe), .pick_num_out(pick_num), .clear_out(clear),
        .dup_ack_out(dup));

    task print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : print_verdict

    // A hang in any wait below ends here instead of running forever.
    always @(posedge clk_in)
    begin
        cyc <= cyc + 1;
        if (cyc == 4000)
        begin
            bad_count++;
            print_verdict;
        end
    end

    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask : tick

    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        tick(1);
        penable <= 1'b1;
        tick(1);
        while (pready !== 1'b1) tick(1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        tick(1);
    endtask : apb

    task pick(input logic [3:0] n, input logic c);
        num <= n;
        sel_req <= 1'b1;
        clr_req <= c;
        tick(1);
        sel_req <= 1'b0;
        clr_req <= 1'b0;
        tick(4);
    endtask : pick

    task irq_wait(input int lim);
        cnt = 0;
        while (irq !== 1'b1 && cnt < lim)
        begin
            tick(1);
            cnt++;
        end
    endtask : irq_wait

    task count_idx;
        cnt = 0;
        index <= 1'b1;
        repeat (8)
        begin
            tick(1);
            cnt += int'(index_o === 1'b1);
        end
        index <= 1'b0;
        tick(2);
    endtask : count_idx

    task start_seek;
        apb(1'b1, ADDR_DECK_NUM, 32'h5);
        speed <= 1'b1;
        pack <= 1'b1;
        online <= 1'b1;
        tick(6);
        check("next deck power", next_pwr, 1);
        check("actuator enable", act_en, 1);
        check("creep to home", act, {1'b1, SPD_CREEP, 1'b0});
        pick(4'h5, 1'b0);
        check("chosen not ready", chosen, 0);
        brush <= 1'b1;
        tick(6);
        check("fast load", act, {1'b1, SPD_FAST, 1'b0});
        loaded <= 1'b1;
        tick(6);
        check("fast reverse", act, {1'b0, SPD_FAST, 1'b0});
        check("usable", usable, 1);
    endtask : start_seek

    initial
    begin
        tick(10);
        sys_rst_in <= 1'b0;
        tick(2);
        check("brush motor on", brush_m, 1);
        apb(1'b0, ADDR_DECK_NUM, 32'h0);
        check("deck number reset", rd, 32'h0);
        apb(1'b1, ADDR_DECK_NUM, 32'h5);
        apb(1'b0, ADDR_DECK_NUM, 32'h0);
        check("deck number", rd, 32'h5);
        apb(1'b1, ADDR_STATUS, 32'hFF);
        check("status write error", err, 0);
        apb(1'b0, 12'h008, 32'h0);
        check("unmapped error", err, 1);
        check("unmapped data", rd, APB_ERR_DATA);
        tick(BR);
        check("brush motor off", brush_m, 0);
        $display("test registers done");
        start_seek;
        tick(HM - 6);
        check("still reverse", act, {1'b0, SPD_FAST, 1'b0});
        tick(8);
        check("slow forward", act, {1'b1, SPD_CREEP, 1'b0});
        track <= 1'b1;
        tick(5);
        check("pawl release", act.pawl_release, 1);
        track <= 1'b0;
        pawl <= 1'b1;
        tick(EG);
        check("no early reached", irq, 0);
        irq_wait(10);
        check("reached irq", irq, 1);
        cnt = 0;
        while (irq === 1'b1 && cnt < 100)
        begin
            tick(1);
            cnt++;
        end
        check("irq width", cnt, IRQ_PULSE_CYC);
        apb(1'b0, ADDR_STATUS, 32'h0);
        check("reached bit", rd[ST_REACHED], 1);
        $display("test first seek done");
        pick(4'h5, 1'b0);
        check("chosen", chosen, 1);
        check("single ack", dup, 0);
        count_idx;
        check("index selected", cnt, 1);
        for (int i = 0; i < 8; i++)
        begin
            rw <= rows[i];
            tick(4);
            check("fault", fault, flt[i]);
            check("currents", {wcur, ecur}, {~flt[i] & rows[i].write_gate,
                ~flt[i] & rows[i].erase_gate});
        end
        rw <= rows[1];
        pick(4'h3, 1'b0);
        check("other number", chosen, 0);
        check("fault unselected", fault, 0);
        check("usable unselected", usable, 1);
        count_idx;
        check("index unselected", cnt, 0);
        rw <= '0;
        pick(4'h5, 1'b0);
        pick(4'h5, 1'b1);
        check("clear wins", chosen, 0);
        ce <= 1'b0;
        pick(4'h5, 1'b0);
        check("frozen select", chosen, 0);
        ce <= 1'b1;
        online <= 1'b0;
        tick(4);
        check("offline", usable, 0);
        online <= 1'b1;
        pack <= 1'b0;
        tick(4);
        check("no pack", usable, 0);
        $display("test select done");
        sys_rst_in <= 1'b1;
        {pack, speed, loaded, online, brush, track, pawl} <= 7'h00;
        tick(3);
        sys_rst_in <= 1'b0;
        tick(1);
        start_seek;
        pick(4'h5, 1'b0);
        rw <= rows[0];
        tick(3);
        check("gate off track", fault, 1);
        rw <= '0;
        pick(4'h3, 1'b0);
        tick(FL - 20);
        check("no early failure", irq, 0);
        irq_wait(40);
        check("failure irq", irq, 1);
        apb(1'b0, ADDR_STATUS, 32'h0);
        check("failed bit", rd[ST_FAILED], 1);
        check("reached bit clear", rd[ST_REACHED], 0);
        $display("test seek failure done");
        print_verdict;
    end
endmodule : tb_top
`default_nettype wire
